// File: logic/pwmovr_top.sv
`timescale 1ns/1ps
// Overview of operation
// - a set select bit lets the generator drive its pin.
// - a cleared select bit drives the pin from its manual bit.
// - under override a manual one drives the pin active.
// - under override a manual zero drives the pin inactive.
// - bits 15-14 and 7-6 ignore writes and read zero.
// - the second instance implements only pin pair 1.
module pwmovr_top #(
   parameter bit SECOND_INSTANCE = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [5:0] gen_level,
   input wire logic [5:0] active_high,
   output logic [5:0] pwm_pin
);
   typedef struct packed {
      logic [15:0] ctrl;
      logic [31:0] rdata;
      logic waitreq;
      logic [5:0] pin;
   } pwmovr_state_s;

   pwmovr_state_s q;
   pwmovr_state_s next_q;
   logic [5:0] pin_comb;
   logic [5:0] pin_enable;
   logic [15:0] wmask;

   function automatic logic [15:0] pwmovr_lane_mask(input logic [3:0] be);
      pwmovr_lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // second instance keeps only pair 1
   assign pin_enable = SECOND_INSTANCE ? pwmovr_pkg::SECOND_INST_MASK
                                       : 6'h3f;
   assign wmask = pwmovr_lane_mask(avs_byteenable) & pwmovr_pkg::CTRL_MASK
                  & {2'h0, pin_enable, 2'h0, pin_enable};

   pwmovr_pin_mux pwmovr_pin_mux_inst (
      .gen_level(gen_level),
      .gen_select(q.ctrl[pwmovr_pkg::SEL_LSB +: 6]),
      .manual_level(q.ctrl[pwmovr_pkg::MAN_LSB +: 6]),
      .active_high(active_high),
      .pin_enable(pin_enable),
      .pin_level(pin_comb)
   );

   always_comb begin
      next_q = q;
      next_q.pin = pin_comb;
      next_q.waitreq = 1'b1;
      if ((avs_read || avs_write) && q.waitreq) begin
         next_q.waitreq = 1'b0;
         if (avs_write && avs_address == pwmovr_pkg::CTRL_OFFSET) begin
            next_q.ctrl = (q.ctrl & ~wmask)
                          | (avs_writedata[15:0] & wmask);
         end
         if (avs_read) begin
            case (avs_address)
               pwmovr_pkg::CTRL_OFFSET:
                  next_q.rdata = {16'h0000, q.ctrl};
               pwmovr_pkg::STATUS_OFFSET:
                  next_q.rdata = {26'h000_0000, q.pin};
               default:
                  next_q.rdata = pwmovr_pkg::UNMAPPED_READ;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q.ctrl <= pwmovr_pkg::CTRL_RESET;
         q.rdata <= 32'h0000_0000;
         q.waitreq <= 1'b1;
         q.pin <= 6'h00;
      end else begin
         q <= next_q;
      end
   end

   assign avs_readdata = q.rdata;
   assign avs_waitrequest = q.waitreq;
   assign pwm_pin = q.pin;

   // pin checks skip the first edge out of reset, whose
   // pin value still holds the reset level
   property p_pin_gen(int i);
      @(posedge ref_clk) disable iff (rst)
      !$past(rst) && pin_enable[i] && q.ctrl[pwmovr_pkg::SEL_LSB+i] |=>
         pwm_pin[i] == $past(gen_level[i]);
   endproperty
   a_pin_gen0: assert property (p_pin_gen(0))
      else $error("pin 0 does not follow generator");
   a_pin_gen1: assert property (p_pin_gen(1))
      else $error("pin 1 does not follow generator");

   property p_manual(int i);
      @(posedge ref_clk) disable iff (rst)
      !$past(rst) && pin_enable[i] && !q.ctrl[pwmovr_pkg::SEL_LSB+i] |=>
         pwm_pin[i] == ($past(q.ctrl[pwmovr_pkg::MAN_LSB+i])
         ~^ $past(active_high[i]));
   endproperty
   a_manual0: assert property (p_manual(0))
      else $error("pin 0 manual level wrong");

   // manual one gives the active level, zero the inactive one
   property p_manual_active(int i);
      @(posedge ref_clk) disable iff (rst)
      !$past(rst) && pin_enable[i] && !q.ctrl[pwmovr_pkg::SEL_LSB+i]
         && q.ctrl[pwmovr_pkg::MAN_LSB+i] |=>
         pwm_pin[i] == $past(active_high[i]);
   endproperty

   property p_manual_inactive(int i);
      @(posedge ref_clk) disable iff (rst)
      !$past(rst) && pin_enable[i] && !q.ctrl[pwmovr_pkg::SEL_LSB+i]
         && !q.ctrl[pwmovr_pkg::MAN_LSB+i] |=>
         pwm_pin[i] != $past(active_high[i]);
   endproperty

   // pins outside the second instance's pair sit inactive
   property p_disabled(int i);
      @(posedge ref_clk) disable iff (rst)
      !$past(rst) && !pin_enable[i] |=>
         pwm_pin[i] != $past(active_high[i]);
   endproperty

   a_manual_act: assert property (p_manual_active(1))
      else $error("pin 1 not driven active");
   a_manual_inact: assert property (p_manual_inactive(5))
      else $error("pin 5 not driven inactive");

   for (genvar k = 0; k < 6; k++) begin : g_pin_chk
      a_gen_each: assert property (p_pin_gen(k))
         else $error("pin does not follow generator");
      a_manual_each: assert property (p_manual(k))
         else $error("pin manual level wrong");
      a_active_each: assert property (p_manual_active(k))
         else $error("pin not driven active");
      a_inactive_each: assert property (p_manual_inactive(k))
         else $error("pin not driven inactive");
      a_disabled_each: assert property (p_disabled(k))
         else $error("unused pin not inactive");
   end

   property p_unimpl;
      @(posedge ref_clk) disable iff (rst)
      q.ctrl[15:14] == 2'h0 && q.ctrl[7:6] == 2'h0;
   endproperty
   a_unimpl: assert property (p_unimpl)
      else $error("unimplemented bits set");

   property p_read_ctrl;
      @(posedge ref_clk) disable iff (rst)
      avs_read && avs_waitrequest
         && avs_address == pwmovr_pkg::CTRL_OFFSET |=>
         avs_readdata[31:14] == 18'h0_0000 && avs_readdata[7:6] == 2'h0;
   endproperty
   a_read_ctrl: assert property (p_read_ctrl)
      else $error("unimplemented bits read nonzero");

   property p_second;
      @(posedge ref_clk) disable iff (rst)
      SECOND_INSTANCE |-> q.ctrl[13:10] == 4'hf && q.ctrl[5:2] == 4'h0;
   endproperty
   a_second: assert property (p_second)
      else $error("second instance upper pairs changed");

   // a write with the high lane off keeps the select bits
   property p_lane_keep;
      @(posedge ref_clk) disable iff (rst)
      avs_write && avs_waitrequest && !avs_byteenable[1]
         && avs_address == pwmovr_pkg::CTRL_OFFSET |=>
         q.ctrl[15:8] == $past(q.ctrl[15:8]);
   endproperty
   a_lane_keep: assert property (p_lane_keep)
      else $error("disabled byte lane written");

   // control moves only on an accepted write
   property p_ctrl_hold;
      @(posedge ref_clk) disable iff (rst)
      !$past(rst) && !(avs_write && avs_waitrequest) |=> $stable(q.ctrl);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold)
      else $error("control changed without a write");

   property p_ack;
      @(posedge ref_clk) disable iff (rst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1
         avs_waitrequest;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer not one cycle later");

   property p_read_status;
      @(posedge ref_clk) disable iff (rst)
      avs_read && avs_waitrequest
         && avs_address == pwmovr_pkg::STATUS_OFFSET |=>
         avs_readdata == {26'h000_0000, $past(pwm_pin)};
   endproperty
   a_read_status: assert property (p_read_status)
      else $error("status read does not show the pins");

   property p_read_unmapped;
      @(posedge ref_clk) disable iff (rst)
      avs_read && avs_waitrequest
         && avs_address != pwmovr_pkg::CTRL_OFFSET
         && avs_address != pwmovr_pkg::STATUS_OFFSET |=>
         avs_readdata == pwmovr_pkg::UNMAPPED_READ;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped)
      else $error("unmapped read not zero");

   // read data holds between reads
   property p_rdata_hold;
      @(posedge ref_clk) disable iff (rst)
      !$past(rst) && !(avs_read && avs_waitrequest) |=>
         $stable(avs_readdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");

   property p_reset;
      @(posedge ref_clk) $fell(rst) |-> q.ctrl == pwmovr_pkg::CTRL_RESET;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset value wrong");

   property p_wait_reset;
      @(posedge ref_clk) $fell(rst) |-> avs_waitrequest;
   endproperty
   a_wait_reset: assert property (p_wait_reset)
      else $error("bus answered straight out of reset");

   c_write: cover property (@(posedge ref_clk) avs_write && !avs_waitrequest);
   c_read: cover property (@(posedge ref_clk) avs_read && !avs_waitrequest);
   c_override: cover property (@(posedge ref_clk) q.ctrl[8] == 1'b0);
   c_manual_active: cover property (@(posedge ref_clk)
      !q.ctrl[8] && q.ctrl[0]);
endmodule

// File: shared/pwmovr_pkg.sv
package pwmovr_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
   localparam int unsigned PAIRS = 3;
   localparam int unsigned PINS = 6;
   localparam int unsigned SEL_LSB = 8;
   localparam int unsigned MAN_LSB = 0;
   localparam logic [15:0] CTRL_RESET = 16'h3f00;
   localparam logic [15:0] CTRL_MASK = 16'h3f3f;
   localparam logic [5:0] SECOND_INST_MASK = 6'h03;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// File: logic/pwmovr_pin_mux.sv
`timescale 1ns/1ps
// per-pin choice between generator and manual level
module pwmovr_pin_mux (
   input wire logic [5:0] gen_level,
   input wire logic [5:0] gen_select,
   input wire logic [5:0] manual_level,
   input wire logic [5:0] active_high,
   input wire logic [5:0] pin_enable,
   output logic [5:0] pin_level
);
   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : g_pin
         always_comb begin
            if (!pin_enable[i]) begin
               pin_level[i] = ~active_high[i];
            end else if (gen_select[i]) begin
               pin_level[i] = gen_level[i];
            end else begin
               // manual 1 = active, 0 = inactive
               pin_level[i] = manual_level[i] ~^ active_high[i];
            end
         end
      end
   endgenerate
endmodule

// File: sim/tb_pwmovr_top.sv
`timescale 1ns/1ps
module tb_pwmovr_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [5:0] gen_level = 6'h00;
   logic [5:0] active_high = 6'h3f;
   logic [5:0] pwm_pin;
   logic [31:0] q;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata2;
   logic avs_waitrequest2;
   logic [5:0] pwm_pin2;
   logic [31:0] q2;
   int failures = 0;
   int checked = 0;
   always #2 ref_clk = ~ref_clk;
   pwmovr_top pwmovr_top_inst (.ref_clk(ref_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .gen_level(gen_level),
      .active_high(active_high), .pwm_pin(pwm_pin));
   // second instance keeps only pin pair 1
   if (1) begin : g_second
      pwmovr_top #(.SECOND_INSTANCE(1'b1)) pwmovr_top_inst (
         .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
         .avs_read(avs_read), .avs_write(avs_write),
         .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
         .avs_readdata(avs_readdata2), .avs_waitrequest(avs_waitrequest2),
         .gen_level(gen_level), .active_high(active_high),
         .pwm_pin(pwm_pin2));
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task end_sim;
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // one Avalon transfer, held until waitrequest is seen low
   task bus(input logic w, input logic [3:0] a, input logic [15:0] d,
            input logic [3:0] b);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      avs_byteenable <= b;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      q2 = avs_readdata2;
      chk("waitrequest 2", {31'h0000_0000, avs_waitrequest2}, 32'h0000_0000);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task pins(input logic [5:0] g, input logic [5:0] p, input logic [5:0] e,
             input logic [5:0] e2);
      @(posedge ref_clk);
      gen_level <= g;
      active_high <= p;
      repeat (2) @(posedge ref_clk);
      #1 chk("pwm_pin", {26'h0, pwm_pin}, {26'h0, e});
      chk("pwm_pin 2", {26'h000_0000, pwm_pin2}, {26'h000_0000, e2});
   endtask
   task t_reset;
      bus(1'b0, 4'h0, 16'h0000, 4'hf);
      chk("ctrl reset", q, 32'h0000_3f00);
      chk("ctrl reset 2", q2, 32'h0000_3f00);
      pins(6'h2d, 6'h3f, 6'h2d, 6'h01);
      pins(6'h12, 6'h3f, 6'h12, 6'h02);
   endtask
   task t_reserved;
      bus(1'b1, 4'h0, 16'hffff, 4'hf);
      bus(1'b0, 4'h0, 16'h0000, 4'hf);
      chk("ctrl reserved", q, 32'h0000_3f3f);
      chk("ctrl reserved 2", q2, 32'h0000_3f03);
      bus(1'b1, 4'h0, 16'h0000, 4'hf);
      bus(1'b0, 4'h0, 16'h0000, 4'hf);
      chk("ctrl zero", q, 32'h0000_0000);
      chk("ctrl zero 2", q2, 32'h0000_3c00);
      bus(1'b1, 4'h0, 16'hffff, 4'h1);
      bus(1'b0, 4'h0, 16'h0000, 4'hf);
      chk("ctrl low lane", q, 32'h0000_003f);
      chk("ctrl low lane 2", q2, 32'h0000_3c03);
      bus(1'b0, 4'h8, 16'h0000, 4'hf);
      chk("unmapped", q, 32'h0000_0000);
      chk("unmapped 2", q2, 32'h0000_0000);
   endtask
   task t_override;
      bus(1'b1, 4'h0, 16'h0015, 4'hf);
      pins(6'h3f, 6'h3f, 6'h15, 6'h01);
      pins(6'h00, 6'h0f, 6'h25, 6'h31);
      bus(1'b1, 4'h0, 16'h0c2a, 4'hf);
      pins(6'h11, 6'h3f, 6'h22, 6'h02);
      bus(1'b0, 4'h4, 16'h0000, 4'hf);
      chk("status", q, 32'h0000_0022);
      chk("status 2", q2, 32'h0000_0002);
   endtask
   task t_rerun;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("pin in reset", {26'h000_0000, pwm_pin}, 32'h0000_0000);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 16'h0000, 4'hf);
      chk("ctrl rerun", q, 32'h0000_3f00);
      chk("ctrl rerun 2", q2, 32'h0000_3f00);
      pins(6'h2d, 6'h3f, 6'h2d, 6'h01);
   endtask
   initial begin
      #20000;
      failures++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_reserved;
      t_override;
      t_rerun;
      end_sim;
   end
endmodule
